// ===== ewsg_core.sv
// External bus wait-state generator with page and I/O wait counts
`timescale 1ns/1ps

// Function
// - Program and data spaces are split into 16K-word pages, each with its own wait count.
// - I/O space has its own generators mapped on two-word or 4K-word boundaries.
// - A wait count is one of 0, 1, 2, 3, 4 or 7, and that many extra cycles are inserted.
// - The external device may stretch an access with ready and the block keeps extending it.
// - I/O ports are reached through data-memory addresses, so data accesses to 0x0050-0x005f reach ports 0 to 15.
// - The I/O space holds 65,536 ports and 16 ports need no external decoding.
// - Every external write takes two machine cycles regardless of the read wait count.
module ewsg_core
    import ewsg_pkg::*;
#(
    parameter int PAGES   = NUM_PAGES,
    parameter int IO_GENS = IO_GEN_NUM
)
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         resetn,
    // Wait configuration
    input  wire logic [PAGES*WAIT_W-1:0]      prog_wait,
    input  wire logic [PAGES*WAIT_W-1:0]      data_wait,
    input  wire logic [IO_GENS*WAIT_W-1:0]    io_wait,
    input  wire logic                         io_coarse,
    // Core request
    input  wire logic                         req_valid,
    input  wire ewsg_req_t                    req,
    output logic                              req_ready,
    output logic                              done,
    // External bus
    output ewsg_bus_t                         bus_q,
    output logic                              strobe_q,
    input  wire logic                         ready_pin
);

    typedef enum {ST_IDLE, ST_WAIT, ST_READY} ewsg_state_t;

    ewsg_state_t        state_q;
    logic [WAIT_W-1:0]  cnt_q;
    logic [WAIT_W-1:0]  wait_sel;
    logic               ready_s;
    logic               io_hit;
    logic [ADDR_W-1:0]  port_addr;

    ewsg_sync u_sync (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (ready_pin),
        .level_out (ready_s)
    );

    // ==========================================================
    // Illegal codes 5 and 6 fall back to the longest count
    function automatic logic [WAIT_W-1:0] legal_wait(input logic [WAIT_W-1:0] w);
        legal_wait = (w > WAIT_LEGAL4 && w != WAIT_MAX) ? WAIT_MAX : w;
    endfunction

    function automatic logic [WAIT_W-1:0] pick(input logic [IO_GENS*WAIT_W-1:0] v,
                                               input int idx);
        pick = v[idx*WAIT_W +: WAIT_W];
    endfunction

    // ==========================================================
    // Address decode and wait selection
    always_comb begin
        int pg;
        int gi;
        pg = 0;
        gi = 0;
        io_hit = (req.space == EWSG_IO) ||
                 (req.space == EWSG_DATA && req.addr >= IO_DATA_BASE
                  && req.addr <= IO_DATA_TOP);
        // Window accesses pick their generator by port number, as direct I/O does
        port_addr = (io_hit && req.space == EWSG_DATA) ? req.addr - IO_DATA_BASE
                                                       : req.addr;
        pg = int'(req.addr[ADDR_W-1:PAGE_BITS]);
        if (io_coarse) begin
            gi = int'(port_addr[ADDR_W-1:IO_COARSE_LSB]);
        end else begin
            gi = int'(port_addr[IO_FINE_LSB +: IO_GEN_BITS]);
        end
        if (io_hit) begin
            wait_sel = legal_wait(pick(io_wait, gi % IO_GENS));
        end else if (req.space == EWSG_PROG) begin
            wait_sel = legal_wait(prog_wait[(pg % PAGES)*WAIT_W +: WAIT_W]);
        end else begin
            wait_sel = legal_wait(data_wait[(pg % PAGES)*WAIT_W +: WAIT_W]);
        end
        if (req.write) begin
            wait_sel = WRITE_CYC - 3'h1;
        end
    end

    assign req_ready = (state_q == ST_IDLE);

    // ==========================================================
    // Access sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= ST_IDLE;
            cnt_q    <= '0;
            strobe_q <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        strobe_q <= 1'b1;
                        cnt_q    <= wait_sel;
                        state_q  <= (wait_sel == '0) ? ST_READY : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (ready_s) begin
                        strobe_q <= 1'b0;
                        done     <= 1'b1;
                        state_q  <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Bus capture, held unchanged for the whole access
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_q <= '0;
        end else if (state_q == ST_IDLE && req_valid) begin
            bus_q.io_sel <= io_hit;
            bus_q.write  <= req.write;
            // Full 16-bit port address; low ports decode with no glue
            bus_q.addr   <= port_addr;
        end
    end

    // ==========================================================
    // Checks
    AST_WAIT_LEN: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && !req.write && wait_sel == 3'h2 && ready_s)
        ##1 ready_s [*3] |-> ##1 done)
        else $error("Two-wait read did not finish on time");
    AST_WRITE_TWO: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.write) ##1 ready_s [*2] |-> ##1 done)
        else $error("Write did not take two cycles");
    AST_READY_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_READY && !ready_s) |=> (strobe_q && !done))
        else $error("Access ended while not ready");
    AST_READY_DONE: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_READY && ready_s) |=> (done && !strobe_q))
        else $error("Ready sample did not finish access");
    AST_LEGAL: assert property (@(posedge clk) disable iff (!resetn)
        state_q == ST_WAIT |-> (cnt_q != 3'h0 && cnt_q <= WAIT_MAX))
        else $error("Wait counter out of range");
    AST_IO_MAP: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.space == EWSG_DATA
         && req.addr == IO_DATA_BASE) |=> (bus_q.io_sel && bus_q.addr == 16'h0000))
        else $error("Data access did not reach I/O port");
    AST_PORT_RANGE: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.space == EWSG_IO)
        |=> (bus_q.addr == $past(req.addr)))
        else $error("I/O port address altered");
    AST_STROBE: assert property (@(posedge clk) disable iff (!resetn)
        $rose(strobe_q) |-> $past(state_q == ST_IDLE && req_valid))
        else $error("Strobe without request");
    AST_GRAN: assert property (@(posedge clk) disable iff (!resetn)
        (req.space == EWSG_IO && !req.write && io_coarse
         && req.addr[ADDR_W-1:IO_COARSE_LSB] == 4'h2
         && io_wait[2*WAIT_W +: WAIT_W] <= WAIT_LEGAL4)
        |-> wait_sel == io_wait[2*WAIT_W +: WAIT_W])
        else $error("Coarse I/O generator not used");

    // ==========================================================
    // Further checks
    AST_WAIT_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && !req.write && wait_sel == 3'h0)
        |=> (state_q == ST_READY && strobe_q))
        else $error("Zero-wait read did not go straight to ready");
    AST_WAIT_SEVEN: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && !req.write && wait_sel == WAIT_MAX && ready_s)
        ##1 ready_s [*8] |-> ##1 done)
        else $error("Seven-wait read did not finish on time");
    AST_NO_FIVE_SIX: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid)
        |-> (wait_sel != 3'h5 && wait_sel != 3'h6))
        else $error("Unsupported wait count loaded");
    AST_WRITE_WAIT: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.write)
        |-> (wait_sel == 3'h1))
        else $error("Write did not load one inserted cycle");
    AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!resetn)
        done
        |=> !done)
        else $error("Done held longer than one cycle");
    AST_BUS_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        (strobe_q && $past(strobe_q))
        |-> $stable(bus_q))
        else $error("Bus changed during an access");
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE)
        |-> !strobe_q)
        else $error("Strobe high while idle");
    AST_IO_WIN_TOP: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.space == EWSG_DATA && req.addr == IO_DATA_TOP)
        |=> (bus_q.io_sel && bus_q.addr == 16'h000f))
        else $error("Top data address did not reach last port");
    AST_FINE_GRAN: assert property (@(posedge clk) disable iff (!resetn)
        (req.space == EWSG_IO && !req.write && !io_coarse
         && req.addr[IO_FINE_LSB +: IO_GEN_BITS] == 4'h3
         && io_wait[3*WAIT_W +: WAIT_W] <= WAIT_LEGAL4)
        |-> wait_sel == io_wait[3*WAIT_W +: WAIT_W])
        else $error("Fine I/O generator not used");
    AST_PAGE_SPLIT: assert property (@(posedge clk) disable iff (!resetn)
        (req.space == EWSG_PROG && !req.write && req.addr[ADDR_W-1:PAGE_BITS] == 2'h2
         && prog_wait[2*WAIT_W +: WAIT_W] <= WAIT_LEGAL4)
        |-> wait_sel == prog_wait[2*WAIT_W +: WAIT_W])
        else $error("Program page wait count not used");
    AST_IO_SEL: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && req_valid && req.space == EWSG_IO)
        |=> bus_q.io_sel)
        else $error("I/O access not marked on the bus");

endmodule

// ===== ewsg_ext_dev.sv
// Model of an external memory or port device that can hold off the bus
`timescale 1ns/1ps
module ewsg_ext_dev (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Bus side
    input  wire logic strobe_q,
    input  wire logic stall,
    output logic      ready_pin
);
    // ==========================================================
    // Ready output
    // A slow device pulls ready low while stall is set, with or without a strobe; in reset it reports ready
    always_comb begin
        ready_pin = (resetn === 1'b1) ? !stall : 1'b1;
    end
endmodule

// ===== ewsg_pkg.sv
// Package with constants and carrier types for the external wait-state generator
package ewsg_pkg;

    // ==========================================================
    // Address map
    localparam int ADDR_W        = 16;
    localparam int PAGE_BITS     = 14;            // 16K-word pages
    localparam int NUM_PAGES     = 4;
    localparam int IO_COARSE_LSB = 12;            // 4K-word I/O blocks
    localparam int IO_FINE_LSB   = 1;             // Two-word I/O blocks
    localparam int IO_GEN_NUM    = 16;
    localparam int IO_GEN_BITS   = 4;
    localparam logic [ADDR_W-1:0] IO_DATA_BASE = 16'h0050;  // I/O window in data space
    localparam logic [ADDR_W-1:0] IO_DATA_TOP  = 16'h005f;
    localparam int IO_WIN_PORTS  = 16;

    // ==========================================================
    // Wait counts
    localparam int WAIT_W = 3;
    localparam logic [WAIT_W-1:0] WAIT_MAX    = 3'h7;
    localparam logic [WAIT_W-1:0] WAIT_LEGAL4 = 3'h4;
    localparam logic [WAIT_W-1:0] WRITE_CYC   = 3'h2;  // Cycles per write
    localparam logic [WAIT_W-1:0] WAIT_RESET  = 3'h7;

    // ==========================================================
    // Spaces and carriers
    typedef enum logic [1:0] {EWSG_PROG, EWSG_DATA, EWSG_IO} ewsg_space_t;

    typedef struct packed {
        ewsg_space_t        space;
        logic               write;
        logic [ADDR_W-1:0]  addr;
    } ewsg_req_t;

    typedef struct packed {
        logic               io_sel;
        logic               write;
        logic [ADDR_W-1:0]  addr;
    } ewsg_bus_t;

endpackage

// ===== ewsg_sync.sv
// Three-stage synchroniser for the external ready pin
`timescale 1ns/1ps
module ewsg_sync
    import ewsg_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and result
    input  wire logic pin_in,
    output logic      level_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ==========================================================
    // Capture chain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==========================================================
    // Change accepted once second and third agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_out <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end

endmodule

// ===== tb_ewsg_core.sv
// Self-checking testbench for the external wait-state generator
`timescale 1ns/1ps
module tb_ewsg_core;
    import ewsg_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, io_coarse = 1'b0, req_valid = 1'b0;
    logic        stall = 1'b0, req_ready, done, strobe_q, ready_pin;
    logic [11:0] prog_wait = 12'h0, data_wait = 12'h0;
    logic [47:0] io_wait = 48'h0;
    ewsg_req_t   req = '0;
    ewsg_bus_t   bus_q;
    int          err_count = 0, cmp_count = 0, cyc = 0, last_n = 0;

    ewsg_core #(.PAGES(4), .IO_GENS(16)) dut (.clk(clk), .resetn(resetn),
        .prog_wait(prog_wait), .data_wait(data_wait), .io_wait(io_wait),
        .io_coarse(io_coarse), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .bus_q(bus_q), .strobe_q(strobe_q),
        .ready_pin(ready_pin));
    ewsg_ext_dev ext (.clk(clk), .resetn(resetn), .strobe_q(strobe_q), .stall(stall),
        .ready_pin(ready_pin));

    // ==========================================================
    // Clock and timeout
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            results();
        end
    end

    // ==========================================================
    // Helpers
    function automatic int legal(input logic [2:0] c);
        return (c > 3'h4) ? 7 : int'(c);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // One access; counts strobe cycles until done, checks bus contents
    task automatic acc(input ewsg_space_t sp, input logic wr, input logic [15:0] a,
                       input int exp_n, input logic eio, input logic [15:0] ea);
        int n;
        int g;
        logic bad;
        n = 0;
        g = 0;
        bad = 1'b0;
        req_valid = 1'b1;
        req = '{space: sp, write: wr, addr: a};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        while (done !== 1'b1 && g < 300) begin
            if (strobe_q === 1'b1) begin
                n++;
                if (bus_q !== {eio, wr, ea}) bad = 1'b1;
            end
            @(posedge clk);
            #1;
            g++;
        end
        chk("bus_q", 32'h0, {31'h0, bad});
        chk("done", 32'h1, {31'h0, done});
        if (exp_n >= 0) chk("strobe_len", exp_n, n);
        last_n = n;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_pages;
        int dw[4] = '{4, 7, 7, 7};
        logic [15:0] pa;
        for (int p = 0; p < 4; p++) begin
            pa = 16'(p << 14) | 16'h0123;
            acc(EWSG_PROG, 1'b0, pa, p + 1, 1'b0, pa);
            pa = 16'(p << 14) | 16'h0200;
            acc(EWSG_DATA, 1'b0, pa, dw[p] + 1, 1'b0, pa);
        end
    endtask

    task automatic t_io;
        logic [15:0] a;
        for (int m = 0; m < 2; m++) begin
            io_coarse = m[0];
            for (int g = 0; g < 16; g++) begin
                a = m ? (16'(g << 12) | 16'h00ab) : (16'hffe0 | 16'(g << 1));
                acc(EWSG_IO, 1'b0, a, legal(g[2:0]) + 1, 1'b1, a);
            end
        end
    endtask

    task automatic t_win;
        io_coarse = 1'b0;
        acc(EWSG_DATA, 1'b0, 16'h0053, 2, 1'b1, 16'h0003);
        acc(EWSG_DATA, 1'b0, 16'h0050, 1, 1'b1, 16'h0000);
        acc(EWSG_DATA, 1'b1, 16'h005f, 2, 1'b1, 16'h000f);
    endtask

    task automatic t_write;
        acc(EWSG_DATA, 1'b1, 16'hc000, 2, 1'b0, 16'hc000);
        acc(EWSG_PROG, 1'b1, 16'h0010, 2, 1'b0, 16'h0010);
        acc(EWSG_DATA, 1'b0, 16'hc000, 8, 1'b0, 16'hc000);
    endtask

    task automatic t_stall;
        stall = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        fork
            acc(EWSG_PROG, 1'b0, 16'h0001, -1, 1'b0, 16'h0001);
            begin
                repeat (30) @(posedge clk);
                #1;
                chk("held", 32'h1, {31'h0, strobe_q});
                stall = 1'b0;
            end
        join
        chk("stall_len", 32'h1, {31'h0, (last_n >= 31 && last_n <= 40)});
    endtask

    task automatic results;
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        prog_wait = {3'h3, 3'h2, 3'h1, 3'h0};
        data_wait = {3'h6, 3'h5, 3'h7, 3'h4};
        for (int g = 0; g < 16; g++) io_wait[3*g +: 3] = g[2:0];
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk("req_ready", 32'h1, {31'h0, req_ready});
        t_pages();
        t_io();
        t_win();
        t_write();
        t_stall();
        results();
    end
endmodule
